// File: hw/tpc_pkg.sv
package tpc_pkg;
  // register index; byte address is four times the index
  localparam int unsigned IDX_W = 8;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_INT_EN = 8'h04;
  localparam logic [IDX_W-1:0] IDX_INT_REQ = 8'h05;
  localparam logic [IDX_W-1:0] IDX_CMP_CTRL = 8'h18;
  localparam logic [IDX_W-1:0] IDX_CMP_SEL = 8'h19;
  localparam logic [IDX_W-1:0] IDX_TM_CTRL [2] = '{8'h1c, 8'h32};
  localparam logic [IDX_W-1:0] IDX_TM_COUNT [2] = '{8'h1d, 8'h33};
  localparam logic [IDX_W-1:0] IDX_TM_SCALE [2] = '{8'h1e, 8'h34};
  localparam logic [IDX_W-1:0] IDX_TM_LIMIT [2] = '{8'h09, 8'h3f};
  localparam logic [7:0] RST_BYTE = 8'h00;
  // interrupt bit positions
  localparam int unsigned INT_TMB = 7;
  localparam int unsigned INT_TMA = 6;
  localparam int unsigned INT_CMP = 4;
  localparam logic [7:0] INT_MASK = 8'hd0;
  // timer clock-select codes
  localparam logic [3:0] CS_OFF = 4'h0;
  localparam logic [3:0] CS_SYS = 4'h1;
  localparam logic [3:0] CS_FAST = 4'h2;
  localparam logic [3:0] CS_XTAL = 4'h3;
  localparam logic [3:0] CS_SLOW = 4'h4;
  localparam logic [3:0] CS_CMP = 4'h5;
  localparam logic [3:0] CS_A0_R = 4'h8;
  localparam logic [3:0] CS_A0_F = 4'h9;
  localparam logic [3:0] CS_B0_R = 4'ha;
  localparam logic [3:0] CS_B0_F = 4'hb;
  localparam logic [3:0] CS_A4_R = 4'hc;
  localparam logic [3:0] CS_A4_F = 4'hd;
  // output-select codes
  localparam logic [1:0] OS_OFF = 2'h0;
  localparam logic [1:0] OS_ONE = 2'h1;
  localparam logic [1:0] OS_TWO = 2'h2;
  localparam logic [1:0] OS_THREE = 2'h3;
  // prescaler terminal counts for divide by 1, 4, 16, 64
  localparam logic [5:0] PRE_TOP [4] = '{6'h00, 6'h03, 6'h0f, 6'h3f};
  // counter tops for 8, 7 and 6 bit pwm
  localparam logic [7:0] TOP_8BIT = 8'hff;
  localparam logic [7:0] TOP_7BIT = 8'h7f;
  localparam logic [7:0] TOP_6BIT = 8'h3f;
  // pin drive vector positions
  localparam int unsigned PIN_A0 = 0;
  localparam int unsigned PIN_A3 = 1;
  localparam int unsigned PIN_B0 = 2;
  localparam int unsigned PIN_B2 = 3;
  localparam int unsigned PIN_B4 = 4;
  localparam int unsigned PIN_B5 = 5;
  localparam int unsigned PIN_B6 = 6;
  localparam int unsigned PIN_B7 = 7;

  typedef struct packed {
    logic [3:0] clk_sel;
    logic [1:0] out_sel;
    logic pwm_mode;
    logic invert;
  } tpc_ctrl_t;

  typedef struct packed {
    logic res_low;
    logic [1:0] pre;
    logic [4:0] scl;
  } tpc_scale_t;

  typedef struct packed {
    logic enable;
    logic result;
    logic sample;
    logic invert;
    logic [2:0] minus_sel;
    logic plus_sel;
  } tpc_cmp_ctrl_t;

  typedef struct packed {
    logic pin_out;
    logic wake;
    logic high_range;
    logic low_range;
    logic [3:0] level;
  } tpc_cmp_sel_t;

  typedef struct packed {
    logic fast;
    logic slow;
    logic xtal;
    logic a_pin0;
    logic b_pin0;
    logic a_pin4;
  } tpc_edge_t;

  typedef struct packed {
    logic [7:0] val;
    logic [7:0] oe;
  } tpc_pins_t;

  typedef struct packed {
    logic enable;
    logic [2:0] minus_sel;
    logic plus_sel;
    logic high_range;
    logic low_range;
    logic [3:0] level;
  } tpc_analog_t;
endpackage : tpc_pkg

// File: hw/tpc_timer_pwm.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// - clock select 0000 stops, 0001 system clock, 0011 crystal, 0100 slow rc, 0101 comparator
// - codes 1000-1101 count rising or falling edges on three port pins
// - code 0010 uses fast rc at single or double rate by build option
// - timer a output: off, port b pin 2 or 0 by option, a3, b4
// - timer b output: off, port b pins 5, 6, 7
// - control bit 1 picks period mode or pwm mode
// - control bit 0 inverts the timer output
// - each 8-bit counter is readable, writable, zero after reset
// - scale bit 7 picks 8-bit or 6/7-bit pwm by build option
// - comparator control bit 7 enables the comparator
// - read-only bit 6 shows the comparator result
// - bit 5 resamples the comparator on the timer a clock
// - bit 4 inverts the comparator result output
// - 3-bit field picks the comparator minus input
// - bit 0 picks the plus input: ladder or port a pin 4
// - select bit 7 drives the comparator output onto port a pin 0
// - select bit 6 wakes the system on a result change
// - select register holds high range, low range and 4-bit ladder level
// - timer a has a write-only limit register, zero after reset
// - timer and comparator request flags stay set until software clears
// - per-source enable bits gate requests, all disabled after reset
module tpc_timer_pwm #(
  parameter bit timer_source_build_option = 1'b0,
  parameter bit pwm_resolution_build_option = 1'b0,
  parameter bit timer_a_out_b0_option = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // oscillator and pin sources, synchronous levels
  input wire logic fast_rc_oscillator,
  input wire logic slow_rc_oscillator,
  input wire logic crystal_oscillator,
  input wire logic port_a_pin0,
  input wire logic port_b_pin0,
  input wire logic port_a_pin4,
  // analog comparator
  input wire logic cmp_plus_above,
  output tpc_pkg::tpc_analog_t cmp_analog,
  // pins, wake and interrupt requests
  output tpc_pkg::tpc_pins_t pin_drive,
  output logic cmp_wake,
  output logic [7:0] irq_req
);
  tpc_pkg::tpc_ctrl_t ctrl_ff [2];
  tpc_pkg::tpc_scale_t scale_ff [2];
  logic [7:0] count_ff [2];
  logic [7:0] limit_ff [2];
  logic [5:0] pre_ff [2];
  logic [4:0] scl_ff [2];
  logic tog_ff [2];
  tpc_pkg::tpc_cmp_ctrl_t cmp_ctrl_ff;
  tpc_pkg::tpc_cmp_sel_t cmp_sel_ff;
  logic [7:0] int_en_ff;
  logic [7:0] int_req_ff;
  logic cmp_res_ff;
  logic cmp_prev_ff;
  logic cmp_out_ff;
  logic cmp_out_prev_ff;
  tpc_pkg::tpc_edge_t prev_ff;
  logic dp_write_ff;
  logic dp_read_ff;
  logic rd_stage_ff;
  logic dp_mapped_ff;
  logic [tpc_pkg::IDX_W-1:0] dp_idx_ff;
  logic [31:0] hrdata_ff;
  tpc_pkg::tpc_pins_t pin_ff;
  logic wake_ff;
  logic [7:0] irq_ff;

  tpc_pkg::tpc_edge_t now_lvl;
  tpc_pkg::tpc_edge_t rise;
  tpc_pkg::tpc_edge_t fall;
  logic cmp_rise;
  logic src_ev [2];
  logic pre_tick [2];
  logic cnt_tick [2];
  logic wrap [2];
  logic tm_event [2];
  logic out_lvl [2];
  logic ap_take;
  logic ap_mapped;
  logic wr_en;
  logic cmp_change;
  tpc_pkg::tpc_pins_t nxt_pin;
  logic [7:0] int_set;

  function automatic logic src_event(input logic [3:0] sel, input tpc_pkg::tpc_edge_t r,
                                     input tpc_pkg::tpc_edge_t f, input logic cr, input logic dbl);
    logic ev;
    ev = 1'b0;
    case (sel)
      tpc_pkg::CS_OFF: ev = 1'b0;
      tpc_pkg::CS_SYS: ev = 1'b1;
      tpc_pkg::CS_FAST: ev = r.fast | (dbl & f.fast);
      tpc_pkg::CS_XTAL: ev = r.xtal;
      tpc_pkg::CS_SLOW: ev = r.slow;
      tpc_pkg::CS_CMP: ev = cr;
      tpc_pkg::CS_A0_R: ev = r.a_pin0;
      tpc_pkg::CS_A0_F: ev = f.a_pin0;
      tpc_pkg::CS_B0_R: ev = r.b_pin0;
      tpc_pkg::CS_B0_F: ev = f.b_pin0;
      tpc_pkg::CS_A4_R: ev = r.a_pin4;
      tpc_pkg::CS_A4_F: ev = f.a_pin4;
      default: ev = 1'b0;
    endcase
    return ev;
  endfunction : src_event

  // bus slave: one cycle address phase, writes commit in the data phase,
  // reads take one wait state so a read right after a write sees the new value
  assign ap_take = hsel & htrans[1] & hready;
  assign ap_mapped = (haddr[31:tpc_pkg::IDX_W+tpc_pkg::IDX_LSB] == '0) && (haddr[tpc_pkg::IDX_LSB-1:0] == '0);
  assign wr_en = dp_write_ff & dp_mapped_ff;
  assign hreadyout = ~(dp_read_ff & ~rd_stage_ff);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_ff <= 1'b0;
      dp_read_ff <= 1'b0;
      rd_stage_ff <= 1'b0;
      dp_mapped_ff <= 1'b0;
      dp_idx_ff <= '0;
    end else begin
      rd_stage_ff <= dp_read_ff & ~rd_stage_ff;
      if (hreadyout) begin
        dp_write_ff <= ap_take & hwrite;
        dp_read_ff <= ap_take & ~hwrite;
        dp_mapped_ff <= ap_take & ap_mapped;
        dp_idx_ff <= haddr[tpc_pkg::IDX_W+tpc_pkg::IDX_LSB-1:tpc_pkg::IDX_LSB];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (dp_read_ff && !rd_stage_ff) begin
      hrdata_ff <= '0;
      if (dp_mapped_ff) begin
        case (dp_idx_ff)
          tpc_pkg::IDX_INT_EN: hrdata_ff[7:0] <= int_en_ff;
          tpc_pkg::IDX_INT_REQ: hrdata_ff[7:0] <= int_req_ff;
          tpc_pkg::IDX_CMP_CTRL: hrdata_ff[7:0] <= {cmp_ctrl_ff.enable, cmp_res_ff, cmp_ctrl_ff[5:0]};
          tpc_pkg::IDX_TM_CTRL[0]: hrdata_ff[7:0] <= ctrl_ff[0];
          tpc_pkg::IDX_TM_COUNT[0]: hrdata_ff[7:0] <= count_ff[0];
          tpc_pkg::IDX_TM_CTRL[1]: hrdata_ff[7:0] <= ctrl_ff[1];
          tpc_pkg::IDX_TM_COUNT[1]: hrdata_ff[7:0] <= count_ff[1];
          default: hrdata_ff[7:0] <= tpc_pkg::RST_BYTE;
        endcase
      end
    end
  end

  // source edges; inputs are already synchronous to hclk
  assign now_lvl = '{fast: fast_rc_oscillator, slow: slow_rc_oscillator, xtal: crystal_oscillator,
                     a_pin0: port_a_pin0, b_pin0: port_b_pin0, a_pin4: port_a_pin4};
  assign rise = now_lvl & ~prev_ff;
  assign fall = ~now_lvl & prev_ff;
  assign cmp_rise = cmp_out_ff & ~cmp_out_prev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= '0;
      cmp_out_prev_ff <= 1'b0;
    end else begin
      prev_ff <= now_lvl;
      cmp_out_prev_ff <= cmp_out_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src_ev[i] = src_event(ctrl_ff[i].clk_sel, rise, fall, cmp_rise, timer_source_build_option);
      // compare with >= so a divider lowered while running does not roll all the way over
      pre_tick[i] = src_ev[i] && (pre_ff[i] >= tpc_pkg::PRE_TOP[scale_ff[i].pre]);
      cnt_tick[i] = pre_tick[i] && (scl_ff[i] >= scale_ff[i].scl);
      if (ctrl_ff[i].pwm_mode) begin
        if (!scale_ff[i].res_low) begin
          wrap[i] = count_ff[i] == tpc_pkg::TOP_8BIT;
        end else if (pwm_resolution_build_option) begin
          wrap[i] = count_ff[i] >= tpc_pkg::TOP_7BIT;
        end else begin
          wrap[i] = count_ff[i] >= tpc_pkg::TOP_6BIT;
        end
        out_lvl[i] = (count_ff[i] < limit_ff[i]) ^ ctrl_ff[i].invert;
      end else begin
        wrap[i] = count_ff[i] == limit_ff[i];
        out_lvl[i] = tog_ff[i] ^ ctrl_ff[i].invert;
      end
      tm_event[i] = cnt_tick[i] & wrap[i];
    end
  end

  // timer registers and counting; a bus write to the counter beats a tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_ff[i] <= tpc_pkg::RST_BYTE;
        scale_ff[i] <= tpc_pkg::RST_BYTE;
        count_ff[i] <= tpc_pkg::RST_BYTE;
        limit_ff[i] <= tpc_pkg::RST_BYTE;
        pre_ff[i] <= '0;
        scl_ff[i] <= '0;
        tog_ff[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_en && dp_idx_ff == tpc_pkg::IDX_TM_CTRL[i]) begin
          ctrl_ff[i] <= hwdata[7:0];
        end
        if (wr_en && dp_idx_ff == tpc_pkg::IDX_TM_SCALE[i]) begin
          scale_ff[i] <= hwdata[7:0];
        end
        if (wr_en && dp_idx_ff == tpc_pkg::IDX_TM_LIMIT[i]) begin
          limit_ff[i] <= hwdata[7:0];
        end
        if (src_ev[i]) begin
          pre_ff[i] <= pre_tick[i] ? 6'h00 : pre_ff[i] + 6'h01;
        end
        if (pre_tick[i]) begin
          scl_ff[i] <= cnt_tick[i] ? 5'h00 : scl_ff[i] + 5'h01;
        end
        if (wr_en && dp_idx_ff == tpc_pkg::IDX_TM_COUNT[i]) begin
          count_ff[i] <= hwdata[7:0];
        end else if (cnt_tick[i]) begin
          count_ff[i] <= wrap[i] ? 8'h00 : count_ff[i] + 8'h01;
        end
        if (tm_event[i] && !ctrl_ff[i].pwm_mode) begin
          tog_ff[i] <= ~tog_ff[i];
        end
      end
    end
  end

  // comparator; the raw result only counts while enabled
  assign cmp_change = cmp_res_ff ^ cmp_prev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_ctrl_ff <= tpc_pkg::RST_BYTE;
      cmp_sel_ff <= tpc_pkg::RST_BYTE;
      cmp_res_ff <= 1'b0;
      cmp_prev_ff <= 1'b0;
      cmp_out_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      if (wr_en && dp_idx_ff == tpc_pkg::IDX_CMP_CTRL) begin
        cmp_ctrl_ff <= hwdata[7:0];
      end
      if (wr_en && dp_idx_ff == tpc_pkg::IDX_CMP_SEL) begin
        cmp_sel_ff <= hwdata[7:0];
      end
      if (!cmp_ctrl_ff.sample || src_ev[0]) begin
        cmp_res_ff <= cmp_ctrl_ff.enable & cmp_plus_above;
      end
      cmp_prev_ff <= cmp_res_ff;
      cmp_out_ff <= cmp_res_ff ^ cmp_ctrl_ff.invert;
      wake_ff <= cmp_change & cmp_sel_ff.wake;
    end
  end

  assign cmp_analog = '{enable: cmp_ctrl_ff.enable, minus_sel: cmp_ctrl_ff.minus_sel,
                        plus_sel: cmp_ctrl_ff.plus_sel, high_range: cmp_sel_ff.high_range,
                        low_range: cmp_sel_ff.low_range, level: cmp_sel_ff.level};
  assign cmp_wake = wake_ff;

  // pin routing
  always_comb begin
    nxt_pin = '0;
    case (ctrl_ff[0].out_sel)
      tpc_pkg::OS_ONE: begin
        nxt_pin.val[timer_a_out_b0_option ? tpc_pkg::PIN_B0 : tpc_pkg::PIN_B2] = out_lvl[0];
        nxt_pin.oe[timer_a_out_b0_option ? tpc_pkg::PIN_B0 : tpc_pkg::PIN_B2] = 1'b1;
      end
      tpc_pkg::OS_TWO: begin
        nxt_pin.val[tpc_pkg::PIN_A3] = out_lvl[0];
        nxt_pin.oe[tpc_pkg::PIN_A3] = 1'b1;
      end
      tpc_pkg::OS_THREE: begin
        nxt_pin.val[tpc_pkg::PIN_B4] = out_lvl[0];
        nxt_pin.oe[tpc_pkg::PIN_B4] = 1'b1;
      end
      default: ;
    endcase
    case (ctrl_ff[1].out_sel)
      tpc_pkg::OS_ONE: begin
        nxt_pin.val[tpc_pkg::PIN_B5] = out_lvl[1];
        nxt_pin.oe[tpc_pkg::PIN_B5] = 1'b1;
      end
      tpc_pkg::OS_TWO: begin
        nxt_pin.val[tpc_pkg::PIN_B6] = out_lvl[1];
        nxt_pin.oe[tpc_pkg::PIN_B6] = 1'b1;
      end
      tpc_pkg::OS_THREE: begin
        nxt_pin.val[tpc_pkg::PIN_B7] = out_lvl[1];
        nxt_pin.oe[tpc_pkg::PIN_B7] = 1'b1;
      end
      default: ;
    endcase
    if (cmp_sel_ff.pin_out) begin
      nxt_pin.val[tpc_pkg::PIN_A0] = cmp_out_ff;
      nxt_pin.oe[tpc_pkg::PIN_A0] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
  assign pin_drive = pin_ff;

  // request flags: a new event wins over a software clear in the same cycle
  always_comb begin
    int_set = '0;
    int_set[tpc_pkg::INT_TMA] = tm_event[0];
    int_set[tpc_pkg::INT_TMB] = tm_event[1];
    int_set[tpc_pkg::INT_CMP] = cmp_change;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_ff <= tpc_pkg::RST_BYTE;
      int_req_ff <= tpc_pkg::RST_BYTE;
      irq_ff <= '0;
    end else begin
      if (wr_en && dp_idx_ff == tpc_pkg::IDX_INT_EN) begin
        int_en_ff <= hwdata[7:0] & tpc_pkg::INT_MASK;
      end
      if (wr_en && dp_idx_ff == tpc_pkg::IDX_INT_REQ) begin
        int_req_ff <= (int_req_ff & hwdata[7:0]) | int_set;
      end else begin
        int_req_ff <= int_req_ff | int_set;
      end
      irq_ff <= int_req_ff & int_en_ff;
    end
  end
  assign irq_req = irq_ff;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_timer_stopped: assert property (
    (ctrl_ff[0].clk_sel == tpc_pkg::CS_OFF) && !wr_en |=> count_ff[0] == $past(count_ff[0]))
    else $error("stopped timer a counted");
  chk_sys_count_up: assert property (
    (ctrl_ff[1].clk_sel == tpc_pkg::CS_SYS) && (scale_ff[1] == 8'h00) && !ctrl_ff[1].pwm_mode
    && (count_ff[1] != limit_ff[1]) && !wr_en |=> count_ff[1] == $past(count_ff[1]) + 8'h01)
    else $error("timer b did not count on system clock");
  chk_period_restart: assert property (
    tm_event[0] && !ctrl_ff[0].pwm_mode && !wr_en |=> (count_ff[0] == 8'h00) && (tog_ff[0] != $past(tog_ff[0])))
    else $error("period restart or toggle missing");
  chk_pwm_pin_level: assert property (
    ctrl_ff[0].pwm_mode && (ctrl_ff[0].out_sel == tpc_pkg::OS_TWO) |=>
    pin_drive.oe[tpc_pkg::PIN_A3] && pin_drive.val[tpc_pkg::PIN_A3] ==
    (($past(count_ff[0]) < $past(limit_ff[0])) ^ $past(ctrl_ff[0].invert)))
    else $error("pwm level wrong on timer a pin");
  chk_req_sticky: assert property (
    int_req_ff[tpc_pkg::INT_TMA] && !(wr_en && dp_idx_ff == tpc_pkg::IDX_INT_REQ) |=> int_req_ff[tpc_pkg::INT_TMA])
    else $error("request flag dropped without clear");
  chk_irq_gating: assert property (
    ##1 irq_req[tpc_pkg::INT_CMP] == ($past(int_req_ff[tpc_pkg::INT_CMP]) && $past(int_en_ff[tpc_pkg::INT_CMP])))
    else $error("comparator request not gated by enable");
  chk_cmp_on_pin: assert property (
    cmp_sel_ff.pin_out |-> ##1 pin_drive.oe[tpc_pkg::PIN_A0] && pin_drive.val[tpc_pkg::PIN_A0] == $past(cmp_out_ff))
    else $error("comparator not on its pin");
  chk_cmp_wake: assert property (
    cmp_sel_ff.wake && $changed(cmp_res_ff) |=> cmp_wake)
    else $error("comparator change gave no wake");
  chk_cmp_disabled: assert property (
    !cmp_ctrl_ff.enable && !cmp_ctrl_ff.sample ##1 !cmp_ctrl_ff.enable |-> !cmp_res_ff)
    else $error("disabled comparator shows a result");
  chk_read_wait: assert property (
    ap_take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cov_period_wrap: cover property (tm_event[0] && !ctrl_ff[0].pwm_mode);
  cov_pwm_wrap: cover property (tm_event[1] && ctrl_ff[1].pwm_mode);
  cov_cmp_wake: cover property (cmp_wake);
endmodule : tpc_timer_pwm

// File: tb/tpc_far_model.sv
`timescale 1ns/1ps
module tpc_far_model (
  // clock
  input wire logic hclk,
  // analog side
  input tpc_pkg::tpc_analog_t cmp_analog,
  input var int a_pin4_mv,
  output logic cmp_plus_above,
  // oscillators, edges kept off the hclk rising edges
  output logic fast_rc_oscillator,
  output logic slow_rc_oscillator,
  output logic crystal_oscillator
);
  int ladder;
  int minus;
  int plus;
  logic junk = 1'b0;
  initial fast_rc_oscillator = 1'b0;
  initial crystal_oscillator = 1'b0;
  initial slow_rc_oscillator = 1'b0;
  always #8 fast_rc_oscillator = ~fast_rc_oscillator;
  always #12 crystal_oscillator = ~crystal_oscillator;
  always #20 slow_rc_oscillator = ~slow_rc_oscillator;
  // a disabled comparator has no settled result, so it wanders every cycle
  always @(posedge hclk) junk <= ~junk;
  always_comb begin
    ladder = 200 * cmp_analog.level + 400 * cmp_analog.high_range;
    plus = cmp_analog.plus_sel ? a_pin4_mv : ladder;
    case (cmp_analog.minus_sel)
      3'h0: minus = 1000;
      3'h1: minus = a_pin4_mv;
      3'h2: minus = 1200;
      3'h3: minus = ladder;
      3'h4: minus = 2000;
      default: minus = 3000;
    endcase
    cmp_plus_above = cmp_analog.enable ? (plus > minus) : junk;
  end
endmodule : tpc_far_model

// File: tb/tpc_timer_pwm_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tpc_timer_pwm_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cmp_plus_above, cmp_wake, b;
  logic fast_rc_oscillator, slow_rc_oscillator, crystal_oscillator, port_a_pin0, port_b_pin0, port_a_pin4;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] irq_req;
  tpc_pkg::tpc_analog_t cmp_analog;
  tpc_pkg::tpc_pins_t pin_drive;
  int failures = 0, checks = 0, seed = 32'h59e58231, a_pin4_mv = 0, n, e, x, lim, scl, pre;
  logic [7:0] mirror [int];
  logic [7:0] oa [4] = '{8'h00, 8'h08, 8'h02, 8'h10};
  logic [7:0] ob [4] = '{8'h00, 8'h20, 8'h40, 8'h80};
  assign hready = hreadyout;
  tpc_timer_pwm dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .fast_rc_oscillator, .slow_rc_oscillator, .crystal_oscillator, .port_a_pin0, .port_b_pin0,
    .port_a_pin4, .cmp_plus_above, .cmp_analog, .pin_drive, .cmp_wake, .irq_req);
  tpc_far_model far_u (.hclk, .cmp_analog, .a_pin4_mv, .cmp_plus_above, .fast_rc_oscillator, .slow_rc_oscillator,
    .crystal_oscillator);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (w) mirror[idx] = wd;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, exp, rd)
  endtask : rdchk
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    conclude();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2; hwdata = '0;
    port_a_pin0 = 1'b0; port_b_pin0 = 1'b0; port_a_pin4 = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (n = 0; n < 2; n++) begin
      rdchk("count reset", tpc_pkg::IDX_TM_COUNT[n], 0);
      x = $random(seed);
      wr(tpc_pkg::IDX_TM_CTRL[n], {4'h0, x[3:0]});
      rdchk("control", tpc_pkg::IDX_TM_CTRL[n], mirror[tpc_pkg::IDX_TM_CTRL[n]]);
      wr(tpc_pkg::IDX_TM_COUNT[n], x[15:8]);
      repeat (4) @(posedge hclk);
      rdchk("stopped count", tpc_pkg::IDX_TM_COUNT[n], x[15:8]);
      wr(tpc_pkg::IDX_TM_LIMIT[n], 8'hff);
      rdchk("limit reads zero", tpc_pkg::IDX_TM_LIMIT[n], 0);
      wr(tpc_pkg::IDX_TM_SCALE[n], 8'h00);
      for (x = 3; x >= 0; x--) begin
        wr(tpc_pkg::IDX_TM_CTRL[n], {4'h0, x[1:0], 2'b00});
        repeat (3) @(posedge hclk);
        `CHK("pin enable", n ? ob[x] : oa[x], pin_drive.oe)
      end
    end
    rdchk("unmapped", 8'h3a, 0);
    $display("test registers done");
    for (n = 1; n < 5; n++) begin
      wr(tpc_pkg::IDX_TM_COUNT[0], 8'h00);
      wr(tpc_pkg::IDX_TM_CTRL[0], {n[3:0], 4'h0});
      repeat (120) @(posedge hclk);
      wr(tpc_pkg::IDX_TM_CTRL[0], 8'h00);
      bus(1'b0, tpc_pkg::IDX_TM_COUNT[0], 8'h00);
      e = (n == 1) ? 120 : (n == 2) ? 30 : (n == 3) ? 20 : 12;
      `CHK("source count", 1'b1, (rd[7:0] >= 8'(e - 1)) && (rd[7:0] <= 8'(e + 4)))
    end
    for (n = 8; n < 14; n++) begin
      wr(tpc_pkg::IDX_TM_COUNT[1], 8'h00);
      wr(tpc_pkg::IDX_TM_CTRL[1], {n[3:0], 4'h0});
      repeat (5) begin
        {port_a_pin4, port_b_pin0, port_a_pin0} <= 3'(1 << ((n - 8) / 2));
        repeat (2) @(posedge hclk);
        {port_a_pin4, port_b_pin0, port_a_pin0} <= 3'h0;
        repeat (2) @(posedge hclk);
      end
      repeat (2) @(posedge hclk);
      wr(tpc_pkg::IDX_TM_CTRL[1], 8'h00);
      rdchk("edge count", tpc_pkg::IDX_TM_COUNT[1], 5);
    end
    $display("test clock sources done");
    lim = $random(seed) & 63;
    pre = $random(seed) & 1;
    scl = $random(seed) & 3;
    wr(tpc_pkg::IDX_TM_LIMIT[1], lim[7:0]);
    wr(tpc_pkg::IDX_TM_SCALE[1], {1'b0, pre[1:0], scl[4:0]});
    wr(tpc_pkg::IDX_TM_COUNT[1], 8'h00);
    wr(tpc_pkg::IDX_TM_CTRL[1], 8'h14);
    for (x = 0; x < 2; x++) begin
      b = pin_drive.val[5];
      e = 0;
      while (pin_drive.val[5] === b && e < 3000) begin
        @(posedge hclk);
        e++;
      end
    end
    `CHK("toggle gap", (lim + 1) * (pre ? 4 : 1) * (scl + 1), e)
    wr(tpc_pkg::IDX_TM_CTRL[1], 8'h00);
    $display("test period done");
    for (n = 0; n < 4; n++) begin
      lim = $random(seed) & 63;
      scl = $random(seed) & 3;
      wr(tpc_pkg::IDX_TM_LIMIT[0], lim[7:0]);
      wr(tpc_pkg::IDX_TM_SCALE[0], {n[1], 2'h0, scl[4:0]});
      wr(tpc_pkg::IDX_TM_CTRL[0], {4'h1, 2'h2, 1'b1, n[0]});
      repeat (300) @(posedge hclk);
      e = 0;
      repeat (256 * (scl + 1)) begin
        @(posedge hclk);
        e += (pin_drive.val[1] === 1'b1);
      end
      x = (n[1] ? 4 : 1) * lim * (scl + 1);
      `CHK("pwm high cycles", n[0] ? 256 * (scl + 1) - x : x, e)
    end
    wr(tpc_pkg::IDX_TM_CTRL[0], 8'h00);
    $display("test pwm done");
    wr(tpc_pkg::IDX_INT_EN, 8'h10);
    wr(tpc_pkg::IDX_CMP_SEL, 8'hda);
    for (n = 0; n < 4; n++) begin
      wr(tpc_pkg::IDX_CMP_CTRL, {3'b100, n[1], 4'h5});
      a_pin4_mv <= n[0] ? 1500 : 900;
      e = 0;
      repeat (10) begin
        @(posedge hclk);
        e += (cmp_wake === 1'b1);
      end
      `CHK("wake pulses", n > 0, e)
      `CHK("pa0 drive", {1'b1, n[0] ^ n[1]}, {pin_drive.oe[0], pin_drive.val[0]})
      rdchk("result", tpc_pkg::IDX_CMP_CTRL, {24'h0, 1'b1, n[0], 1'b0, n[1], 4'h5});
    end
    `CHK("analog", 11'h55a, cmp_analog)
    wr(tpc_pkg::IDX_CMP_CTRL, 8'ha5);
    a_pin4_mv <= 900;
    repeat (5) @(posedge hclk);
    rdchk("held result", tpc_pkg::IDX_CMP_CTRL, 32'he5);
    wr(tpc_pkg::IDX_TM_CTRL[0], 8'h10);
    repeat (5) @(posedge hclk);
    rdchk("sampled result", tpc_pkg::IDX_CMP_CTRL, 32'ha5);
    wr(tpc_pkg::IDX_TM_CTRL[0], 8'h00);
    `CHK("irq on", 8'h10, irq_req)
    wr(tpc_pkg::IDX_INT_EN, 8'h00);
    repeat (2) @(posedge hclk);
    `CHK("irq masked", 8'h00, irq_req)
    wr(tpc_pkg::IDX_INT_EN, 8'h10);
    repeat (2) @(posedge hclk);
    `CHK("irq held", 8'h10, irq_req)
    wr(tpc_pkg::IDX_INT_REQ, 8'h00);
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 8'h00, irq_req)
    $display("test comparator done");
    conclude();
  end
endmodule : tpc_timer_pwm_bench
